// *** pkg/fldcr_pkg.sv ***
package fldcr_pkg;
  // Bus geometry: printed offsets are word indices
  localparam int PADDR_W = 10;
  localparam logic [7:0] IDX_CFG = 8'h2D;
  localparam logic [7:0] IDX_THR = 8'h2E;
  localparam logic [7:0] IDX_GEN3 = 8'h31;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
  // Reset values
  localparam logic [15:0] RST_CFG = 16'h0000;
  localparam logic [15:0] RST_THR = 16'h0221;
  localparam logic [15:0] RST_GEN3 = 16'h10B0;
  // Writable bits; the rest read as zero, except the CFG stuck and cause bits
  localparam logic [15:0] CFG_WMASK = 16'hC01F;
  localparam logic [15:0] THR_WMASK = 16'h0777;
  localparam logic [15:0] GEN3_WMASK = 16'h71FD;
  // Field positions
  localparam int CFG_FORCE_BIT = 15;
  localparam int CFG_SKIP_BIT = 14;
  localparam int CFG_STUCK_BIT = 13;
  localparam int CAUSE_HI = 12;
  localparam int CAUSE_LO = 8;
  localparam int MODE_HI = 4;
  localparam int MODE_LO = 0;
  localparam int WIN_HI = 10;
  localparam int WIN_LO = 8;
  localparam int ON_HI = 6;
  localparam int ON_LO = 4;
  localparam int OFF_HI = 2;
  localparam int OFF_LO = 0;
  localparam int AN_HI = 6;
  localparam int AN_LO = 5;
  localparam int MIRROR_BIT = 0;
  // Criteria and interrupt layout
  localparam int NCRIT = 5;
  localparam int IRQ_W = 6;
  // Pin vector positions
  localparam int PIN_RX = 0;
  localparam int PIN_MSE = 1;
  localparam int PIN_MLT3 = 2;
  localparam int PIN_RXE = 3;
  localparam int PIN_DSC = 4;
  localparam int PIN_NRG = 5;
  localparam int PIN_STK = 6;
  localparam int PIN_N = 7;
  // Negotiation timer selections
  localparam logic [1:0] AN_SEL_1M6 = 2'h0;
  localparam logic [1:0] AN_SEL_2US = 2'h1;
  localparam logic [1:0] AN_SEL_800U = 2'h2;
  localparam logic [1:0] AN_SEL_11M = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int AN_T00_NS = 1600000;
  localparam int AN_T01_NS = 2000;
  localparam int AN_T10_NS = 800000;
  localparam int AN_T11_NS = 11000000;
  localparam int MAX_WAIT_NS = 10000;
  localparam int ENERGY_UNIT_SHIFT = 4;
  localparam int TMR_W = 22;
  function automatic int fldcr_ns_to_cyc(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
  localparam int AN_T01_CYC = fldcr_ns_to_cyc(AN_T01_NS);
  localparam logic [TMR_W-1:0] MAX_WAIT_CYC =
    TMR_W'(fldcr_ns_to_cyc(MAX_WAIT_NS));
  // Drop sequencer states
  typedef enum logic [1:0] {st_idle, st_wait, st_down} fldcr_drop_type;
endpackage

// *** pkg/fldcr_timer_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fldcr_timer_if;
  import fldcr_pkg::*;
  logic load; // Start pulse
  logic [TMR_W-1:0] count; // Cycles to run
  logic busy; // Running
  logic done; // One-cycle expiry pulse
  modport owner(output load, output count, input busy, input done);
  modport timer(input load, input count, output busy, output done);
endinterface
`default_nettype wire

// *** rtl/fldcr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module fldcr_regs
  import fldcr_pkg::*;
#(
  parameter logic [TMR_W-1:0] AN_1M6_CYC = TMR_W'(fldcr_ns_to_cyc(AN_T00_NS)),
  parameter logic [TMR_W-1:0] AN_800U_CYC = TMR_W'(fldcr_ns_to_cyc(AN_T10_NS)),
  parameter logic [TMR_W-1:0] AN_11M_CYC = TMR_W'(fldcr_ns_to_cyc(AN_T11_NS))
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_signal_pin,
  input wire logic mse_fault_pin,
  input wire logic mlt3_error_pin,
  input wire logic rx_error_pin,
  input wire logic descr_loss_pin,
  input wire logic energy_sample_pin,
  input wire logic slicer_stuck_pin,
  input wire logic an_timer_start,
  output logic link_down,
  output logic energy_detected,
  output logic energy_lost,
  output logic an_timer_expired,
  output logic port_mirror_en,
  output logic irq
);
  // Pin synchronisers
  logic [PIN_N-1:0] pin_meta; // First stage, read by pin_sync only
  logic [PIN_N-1:0] pin_sync;
  logic [PIN_N-1:0] pins;
  assign pins = {slicer_stuck_pin, energy_sample_pin, descr_loss_pin,
                 rx_error_pin, mlt3_error_pin, mse_fault_pin, rx_signal_pin};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pins;
      pin_sync <= pin_meta;
    end
  end

  // Register state
  logic [15:0] cfg_rw, next_cfg_rw; // Writable control bits
  logic [NCRIT-1:0] cause, next_cause; // Latched drop causes
  logic [15:0] thr, next_thr; // Energy thresholds
  logic [15:0] gen3, next_gen3; // General config three
  logic [IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [NCRIT-1:0] rd_snap, next_rd_snap; // Causes shown to reader
  logic [7:0] acc_idx, next_acc_idx; // Index of pending access
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq, next_mirror;

  // Field views
  logic rx_sig, force_en, skip;
  logic [NCRIT-1:0] armed, crit_now, cause_set;
  logic [2:0] win_len, on_thr, off_thr;
  logic [1:0] an_sel;
  assign rx_sig = pin_sync[PIN_RX];
  assign force_en = cfg_rw[CFG_FORCE_BIT];
  assign skip = cfg_rw[CFG_SKIP_BIT];
  assign armed = cfg_rw[MODE_HI:MODE_LO];
  assign win_len = thr[WIN_HI:WIN_LO];
  assign on_thr = thr[ON_HI:ON_LO];
  assign off_thr = thr[OFF_HI:OFF_LO];
  assign an_sel = gen3[AN_HI:AN_LO];
  // Criterion order follows the select field
  assign crit_now = {pin_sync[PIN_DSC], pin_sync[PIN_RXE],
                     pin_sync[PIN_MLT3], pin_sync[PIN_MSE], energy_lost};
  // Each armed bit gates only its own criterion
  assign cause_set = armed & crit_now;

  // Bus phases
  logic [7:0] idx;
  logic setup, done, wr, rd_done, hit;
  logic [15:0] rd16;
  logic [IRQ_W-1:0] w1c;
  logic an_done;
  assign idx = paddr[PADDR_W-1:2];
  assign setup = psel & ~penable;
  assign done = psel & penable & pready;
  assign wr = done & pwrite;
  assign rd_done = done & ~pwrite;

  // Read mux and register next values
  always_comb begin
    hit = 1'b1;
    rd16 = 16'h0000;
    case (idx)
      IDX_CFG: begin
        rd16 = cfg_rw;
        rd16[CFG_STUCK_BIT] = pin_sync[PIN_STK];
        rd16[CAUSE_HI:CAUSE_LO] = cause;
      end
      IDX_THR: rd16 = thr;
      IDX_GEN3: rd16 = gen3;
      IDX_IRQ_STAT: rd16 = {{(16-IRQ_W){1'b0}}, irq_stat};
      IDX_IRQ_MASK: rd16 = {{(16-IRQ_W){1'b0}}, irq_mask};
      default: hit = 1'b0;
    endcase
    // No wait state: pready and read data come from flops loaded in the setup phase
    next_pready = setup;
    next_pslverr = setup & ~hit;
    next_prdata = prdata;
    next_acc_idx = acc_idx;
    next_rd_snap = rd_snap;
    if (setup) begin
      next_prdata = pwrite ? 32'h0000_0000 : {16'h0000, rd16};
      next_acc_idx = idx;
      next_rd_snap = cause;
    end
    // Masked writes keep read-only bits at zero
    next_cfg_rw = cfg_rw;
    next_thr = thr;
    next_gen3 = gen3;
    next_irq_mask = irq_mask;
    w1c = '0;
    if (wr) begin
      case (idx)
        IDX_CFG: next_cfg_rw = pwdata[15:0] & CFG_WMASK;
        IDX_THR: next_thr = pwdata[15:0] & THR_WMASK;
        IDX_GEN3: next_gen3 = pwdata[15:0] & GEN3_WMASK;
        IDX_IRQ_STAT: w1c = pwdata[IRQ_W-1:0];
        IDX_IRQ_MASK: next_irq_mask = pwdata[IRQ_W-1:0];
        default: next_cfg_rw = cfg_rw;
      endcase
    end
    // Only causes the reader saw are cleared; a new set wins
    next_cause = cause | cause_set;
    if (rd_done && acc_idx == IDX_CFG) begin
      next_cause = (cause & ~rd_snap) | cause_set;
    end
    next_irq_stat = (irq_stat & ~w1c) | {an_done, cause_set};
    next_irq = |(next_irq_stat & next_irq_mask);
    next_mirror = next_gen3[MIRROR_BIT];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rw <= RST_CFG;
      cause <= '0;
      thr <= RST_THR;
      gen3 <= RST_GEN3;
      irq_stat <= '0;
      irq_mask <= '0;
      rd_snap <= '0;
      acc_idx <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      port_mirror_en <= 1'b0;
    end else begin
      cfg_rw <= next_cfg_rw;
      cause <= next_cause;
      thr <= next_thr;
      gen3 <= next_gen3;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      rd_snap <= next_rd_snap;
      acc_idx <= next_acc_idx;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      port_mirror_en <= next_mirror;
    end
  end

  // Energy detector: window counter and saturating accumulator
  logic [7:0] win_cnt, next_win_cnt, win_lim;
  logic [2:0] acc, next_acc;
  logic win_end, next_det, next_lost;
  assign win_lim = 8'(({5'h00, win_len} + 8'h01) << ENERGY_UNIT_SHIFT);
  assign win_end = win_cnt >= win_lim - 8'h01;

  always_comb begin
    next_win_cnt = win_cnt + 8'h01;
    next_acc = acc;
    next_det = energy_detected;
    next_lost = energy_lost;
    if (win_end) begin
      next_win_cnt = 8'h00;
      next_acc = 3'h0;
      next_det = acc > on_thr;
      next_lost = acc < off_thr;
    end else if (pin_sync[PIN_NRG] && acc != 3'h7) begin
      next_acc = acc + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      win_cnt <= 8'h00;
      acc <= 3'h0;
      energy_detected <= 1'b0;
      energy_lost <= 1'b0;
    end else begin
      win_cnt <= next_win_cnt;
      acc <= next_acc;
      energy_detected <= next_det;
      energy_lost <= next_lost;
    end
  end

  // Drop sequencer with maximum wait timer
  fldcr_timer_if wait_tif ();
  fldcr_timer_if an_tif ();
  fldcr_timer u_wait (.clk(clk), .rst_b(rst_b), .tif(wait_tif.timer));
  fldcr_timer u_an (.clk(clk), .rst_b(rst_b), .tif(an_tif.timer));

  fldcr_drop_type drop_st, next_drop_st;
  logic fire, wait_load, next_link_down;
  assign fire = |cause_set;
  assign wait_tif.load = wait_load;
  assign wait_tif.count = MAX_WAIT_CYC;

  always_comb begin
    next_drop_st = drop_st;
    wait_load = 1'b0;
    case (drop_st)
      st_idle: begin
        if (fire && skip) begin
          next_drop_st = st_down;
        end else if (fire) begin
          next_drop_st = st_wait;
          wait_load = 1'b1;
        end
      end
      st_wait: begin
        // Criterion gone before expiry: the link survives
        if (skip || wait_tif.done) begin
          next_drop_st = st_down;
        end else if (!fire) begin
          next_drop_st = st_idle;
        end
      end
      st_down: begin
        if (!fire && rx_sig) begin
          next_drop_st = st_idle;
        end
      end
      default: next_drop_st = st_idle;
    endcase
    // Force drop overrides the sequencer while the medium is silent
    next_link_down = (next_drop_st == st_down) | (force_en & ~rx_sig);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drop_st <= st_idle;
      link_down <= 1'b0;
    end else begin
      drop_st <= next_drop_st;
      link_down <= next_link_down;
    end
  end

  // Negotiation timer; duration latched at start
  logic [TMR_W-1:0] an_count;
  assign an_tif.load = an_timer_start;
  assign an_tif.count = an_count;
  assign an_done = an_tif.done;

  always_comb begin
    case (an_sel)
      AN_SEL_1M6: an_count = AN_1M6_CYC;
      AN_SEL_2US: an_count = TMR_W'(AN_T01_CYC);
      AN_SEL_800U: an_count = AN_800U_CYC;
      AN_SEL_11M: an_count = AN_11M_CYC;
      default: an_count = AN_1M6_CYC;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      an_timer_expired <= 1'b0;
    end else begin
      an_timer_expired <= an_done;
    end
  end

  // Helper: cycles since last timer start, for checking only
  localparam int AN_SHORT_DLY = AN_T01_CYC + 1;
  logic [8:0] an_age;
  logic [1:0] an_sel_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      an_age <= 9'h1FF;
      an_sel_q <= 2'h0;
    end else if (an_timer_start) begin
      an_age <= 9'h000;
      an_sel_q <= an_sel;
    end else if (an_age != 9'h1FF) begin
      an_age <= an_age + 9'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_force_drop: assert property (
    force_en && !rx_sig |=> link_down)
    else $error("link not dropped under force drop");
  // Next-cycle check: a brief criterion may legally let the link recover
  a_skip_wait: assert property (
    drop_st == st_idle && fire && skip |=> drop_st == st_down && link_down)
    else $error("skip wait did not drop at once");
  a_wait_kept: assert property (
    drop_st == st_idle && fire && !skip |=> drop_st == st_wait)
    else $error("wait interval not entered");
  a_cause_hold: assert property (
    !(rd_done && acc_idx == IDX_CFG) |=> (cause & $past(cause)) == $past(cause))
    else $error("cause flag lost without read");
  a_cause_clear: assert property (
    rd_done && acc_idx == IDX_CFG && cause_set == '0
    |=> (cause & $past(rd_snap)) == '0)
    else $error("cause flag not cleared by read");
  a_crit_map: assert property (
    armed[PIN_RXE-PIN_RX] && pin_sync[PIN_RXE]
    |=> cause[PIN_RXE-PIN_RX] && drop_st != st_idle)
    else $error("receive error criterion ignored");
  a_energy_on: assert property (
    win_end && acc > on_thr |=> energy_detected)
    else $error("energy detected not raised");
  a_energy_lost: assert property (
    win_end && acc < off_thr |=> energy_lost)
    else $error("energy lost not raised");
  a_an_short: assert property (
    an_age == 9'(AN_SHORT_DLY) && an_sel_q == AN_SEL_2US |-> an_timer_expired)
    else $error("short negotiation timer wrong length");
  a_rsvd_zero: assert property (
    pready && acc_idx == IDX_THR |-> (prdata[15:0] & ~THR_WMASK) == 16'h0000)
    else $error("reserved bits read nonzero");
  // A mask write in the same cycle may legally lower the line
  a_irq_level: assert property (
    (irq_stat & irq_mask) != '0 && w1c == '0 && !(wr && idx == IDX_IRQ_MASK)
    |=> irq)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

// *** rtl/fldcr_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module fldcr_timer
  import fldcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  fldcr_timer_if.timer tif
);
  logic [TMR_W-1:0] rem; // Cycles left
  logic [TMR_W-1:0] next_rem;
  logic next_busy;
  logic next_done;

  // Down-count; a fresh load restarts it
  always_comb begin
    next_rem = rem;
    next_busy = tif.busy;
    next_done = 1'b0;
    if (tif.load) begin
      next_rem = tif.count;
      next_busy = 1'b1;
    end else if (tif.busy) begin
      next_rem = rem - TMR_W'(1);
      if (rem <= TMR_W'(1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rem <= '0;
      tif.busy <= 1'b0;
      tif.done <= 1'b0;
    end else begin
      rem <= next_rem;
      tif.busy <= next_busy;
      tif.done <= next_done;
    end
  end
endmodule
`default_nettype wire

// *** verif/fldcr_medium.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far end of the cable plus the front end that turns line
// conditions into status pins; lag gives a slow answer
module fldcr_medium (
  input wire logic clk,
  input wire logic link_ok, // Far end transmitting
  input wire logic [4:1] fault, // Impairments: mse, mlt3, rx err, descr
  input wire logic energy_on, // Far end putting energy on the pair
  input wire logic [3:0] lag, // Extra cable delay in cycles
  output logic rx_signal_pin,
  output logic mse_fault_pin,
  output logic mlt3_error_pin,
  output logic rx_error_pin,
  output logic descr_loss_pin,
  output logic energy_sample_pin,
  output logic slicer_stuck_pin
);
  // Delay line, preset to a quiet healthy link so no pin starts unknown
  logic [5:0] pipe [16] = '{default: 6'h21};
  // Shift line state down the cable
  always_ff @(posedge clk) begin
    pipe[0] <= {energy_on, fault, link_ok};
    for (int i = 1; i < 16; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  // Tap picks the delay
  assign {energy_sample_pin, descr_loss_pin, rx_error_pin, mlt3_error_pin,
    mse_fault_pin, rx_signal_pin} = pipe[lag];
  // Slicer never stuck in this model
  assign slicer_stuck_pin = 1'b0;
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fldcr_pkg::*;
  logic clk = 1'b0; // Core clock
  logic rst_b = 1'b0; // Reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, d; // Bus data, last read
  logic pready, pslverr, err, link_down, energy_detected, energy_lost;
  logic an_timer_expired, port_mirror_en, irq, an_timer_start = 1'b0;
  logic rx_signal_pin, mse_fault_pin, mlt3_error_pin, rx_error_pin;
  logic descr_loss_pin, energy_sample_pin, slicer_stuck_pin;
  logic link_ok = 1'b1, energy_on = 1'b1; // Medium state
  logic [4:1] fault = '0; // Impairments to inject
  logic [3:0] lag = '0; // Cable delay
  int n_errors = 0, num_checks = 0, k;
  logic [7:0] ix [3] = '{IDX_CFG, IDX_THR, IDX_GEN3};
  logic [15:0] rv [3] = '{16'h0000, 16'h0221, 16'h10B0}; // Reset words
  logic [15:0] wm [3] = '{16'hC01F, 16'h0777, 16'h71FD}; // Kept bits
  int tn [4] = '{20, 400, 10, 40}; // Timer lengths; all but the 2 us one shortened
  always #2.5 clk = ~clk; // 200 MHz
  fldcr_regs #(.AN_1M6_CYC(22'd20), .AN_800U_CYC(22'd10),
    .AN_11M_CYC(22'd40)) uut (.clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_signal_pin,
    .mse_fault_pin, .mlt3_error_pin, .rx_error_pin, .descr_loss_pin,
    .energy_sample_pin, .slicer_stuck_pin, .an_timer_start, .link_down,
    .energy_detected, .energy_lost, .an_timer_expired, .port_mirror_en,
    .irq);
  fldcr_medium far (.clk, .link_ok, .fault, .energy_on, .lag,
    .rx_signal_pin, .mse_fault_pin, .mlt3_error_pin, .rx_error_pin,
    .descr_loss_pin, .energy_sample_pin, .slicer_stuck_pin);
  // Report counts, verdict, stop
  task automatic give_verdict();
    $display("checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // One APB transfer; no cycle count assumed, only a bound
  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) begin
      n_errors++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Wait for an output to reach v; k counts edges taken
  task automatic waitv(input int which, input logic v, input int lim);
    logic s;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      case (which)
        0: s = link_down;
        1: s = energy_detected;
        2: s = energy_lost;
        default: s = an_timer_expired;
      endcase
    end while (s !== v && k < lim);
    num_checks++;
    if (s !== v) begin
      $display("unexpected wait %0d: expected %b, seen %b", which, v, s);
      n_errors++;
    end
  endtask
  // Hang guard
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h583AD3C3));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Reset words, then random writes read back through masks
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ix[i], 32'h0);
      chk("reset word", {16'h0, rv[i]}, rd);
    end
    chk("mirror reset", 32'h0, {31'h0, port_mirror_en});
    for (int i = 0; i < 9; i++) begin
      d = $urandom;
      apb(1'b1, ix[i%3], d);
      apb(1'b0, ix[i%3], 32'h0);
      chk("readback", {16'h0, d[15:0] & wm[i%3]}, rd);
      chk("mirror", {31'h0, (i % 3 == 2) && d[0]}, {31'h0, port_mirror_en});
      apb(1'b1, IDX_GEN3, {16'h0, rv[2]});
    end
    // Unmapped place refuses and reads zero
    apb(1'b1, 8'h30, 32'hFFFF);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    apb(1'b1, IDX_THR, 32'h0221);
    apb(1'b1, IDX_IRQ_STAT, 32'h3F);
    // Each criterion alone, skip set, varying delay and mask
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, IDX_IRQ_MASK, (i == 2) ? 32'h0 : 32'h3F);
      apb(1'b1, IDX_CFG, 32'h4000 | (32'h1 << i));
      lag <= 4'(i);
      if (i == 0) begin
        energy_on <= 1'b0;
      end else begin
        fault[i] <= 1'b1;
      end
      waitv(0, 1'b1, 120);
      chk("irq", {31'h0, i != 2}, {31'h0, irq});
      apb(1'b0, IDX_CFG, 32'h0);
      chk("cause", 32'h4000 | (32'h101 << i), rd);
      apb(1'b0, IDX_IRQ_STAT, 32'h0);
      chk("irq status", 32'h1 << i, rd);
      energy_on <= 1'b1;
      fault <= '0;
      waitv(0, 1'b0, 150);
      apb(1'b0, IDX_CFG, 32'h0);
      apb(1'b0, IDX_CFG, 32'h0);
      chk("cause cleared", 32'h4000 | (32'h1 << i), rd);
      apb(1'b1, IDX_IRQ_STAT, 32'h3F);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    // Unarmed faults ignored; armed without skip waits the interval
    apb(1'b1, IDX_CFG, 32'h0);
    fault <= 4'hF;
    repeat (40) @(posedge clk);
    apb(1'b0, IDX_CFG, 32'h0);
    chk("unarmed cause", 32'h0, rd);
    chk("unarmed drop", 32'h0, {31'h0, link_down});
    apb(1'b1, IDX_CFG, 32'h0008);
    repeat (1900) @(posedge clk);
    chk("early drop", 32'h0, {31'h0, link_down});
    waitv(0, 1'b1, 200);
    fault <= '0;
    waitv(0, 1'b0, 20);
    // Force drop only while no signal arrives
    apb(1'b1, IDX_CFG, 32'h0);
    link_ok <= 1'b0;
    repeat (10) @(posedge clk);
    chk("unforced drop", 32'h0, {31'h0, link_down});
    apb(1'b1, IDX_CFG, 32'h8000);
    waitv(0, 1'b1, 10);
    link_ok <= 1'b1;
    waitv(0, 1'b0, 10);
    // Threshold edges: saturated count 7 is not above 7 nor below 7
    apb(1'b1, IDX_CFG, 32'h0);
    apb(1'b1, IDX_THR, 32'h0071);
    repeat (40) @(posedge clk);
    chk("on at seven", 32'h0, {31'h0, energy_detected});
    apb(1'b1, IDX_THR, 32'h0767);
    waitv(1, 1'b1, 140);
    repeat (40) @(posedge clk);
    chk("lost at seven", 32'h0, {31'h0, energy_lost});
    // Longest window: one full window between two decisions
    apb(1'b1, IDX_THR, 32'h0721);
    energy_on <= 1'b0;
    waitv(2, 1'b1, 300);
    energy_on <= 1'b1;
    waitv(2, 1'b0, 300);
    chk("window cycles", 32'd128, k);
    // Drop the receive-error event left from the wait-interval test
    apb(1'b1, IDX_IRQ_STAT, 32'h3F);
    // Every negotiation timer selection
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, IDX_GEN3, 32'h1090 | (s << 5));
      an_timer_start <= 1'b1;
      @(posedge clk);
      an_timer_start <= 1'b0;
      waitv(3, 1'b1, 500);
      chk("timer cycles", tn[s] + 2, k);
    end
    apb(1'b0, IDX_IRQ_STAT, 32'h0);
    chk("timer event", 32'h20, rd);
    give_verdict();
  end
endmodule
`default_nettype wire
